// *** src/asmc_defs.svh ***
// register map, field positions and reset values of the auto serial unit
`ifndef ASMC_DEFS_SVH
`define ASMC_DEFS_SVH
`define ASMC_ADDR_MODE 16'hff90
`define ASMC_ADDR_STATUS 16'hff91
`define ASMC_ADDR_TRIGGER 16'hff92
`define ASMC_ADDR_SHIFT 16'hff93
`define ASMC_ADDR_END_PTR 16'hff94
`define ASMC_ADDR_ADDR_CNT 16'hff95
`define ASMC_ADDR_BUF_BASE 16'hfa00
`define ASMC_MODE_RESET 8'h00
`define ASMC_BIT_ENABLE 7
`define ASMC_BIT_AUTO 6
`define ASMC_BIT_REPEAT 5
`define ASMC_BIT_MASTER 4
`define ASMC_BIT_TX_EN 3
`define ASMC_BIT_RX_EN 2
`define ASMC_BIT_FIRST 1
`define ASMC_MODE_WMASK 8'hfe
`define ASMC_BIT_BUSY 0
`define ASMC_BIT_START 0
`define ASMC_BITS_PER_BYTE 4'h8
`endif

// *** src/asmc_pkg.sv ***
// types of the auto serial unit
package asmc_pkg;
  typedef enum logic [1:0] {
    ASMC_IDLE = 2'b00,
    ASMC_SHIFT = 2'b01,
    ASMC_WAIT = 2'b10
  } asmc_state_t;
endpackage : asmc_pkg

// *** src/asmc_buf2.sv ***
// two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module asmc_buf2 #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic flush,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  logic [WIDTH-1:0] slot0;
  logic [WIDTH-1:0] slot1;
  logic [1:0] count;
  logic push;
  logic pop;

  initial
  begin
    if (WIDTH < 1) $error("asmc_buf2: WIDTH must be at least 1");
  end

  assign inReady = (count != 2'd2);
  assign outValid = (count != 2'd0);
  assign outData = slot0;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge clk)
  begin
    if (!resetn || flush)
      count <= 2'd0;
    else if (push && !pop)
      count <= count + 2'd1;
    else if (pop && !push)
      count <= count - 2'd1;
  end

  // slot0 is always the head, so the output comes straight from a flop
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      slot0 <= '0;
      slot1 <= '0;
    end
    else
    begin
      if (pop)
        slot0 <= (count == 2'd2) ? slot1 : inData;
      else if (push && count == 2'd0)
        slot0 <= inData;
      if (push && ((count == 2'd1 && !pop) || (count == 2'd2)))
        slot1 <= inData;
    end
  end
endmodule : asmc_buf2
`default_nettype wire

// *** src/asmc_auto_serial.sv ***
// three-wire serial unit with automatic buffer-memory transfer
`timescale 1ns/100ps
`default_nettype none
`include "asmc_defs.svh"
module asmc_auto_serial #(
  parameter int BUF_DEPTH = 32,
  parameter int SCK_HALF_DIV = 4
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [15:0] cpuAddr,
  input wire logic [7:0] cpuWrData,
  input wire logic cpuWrite,
  input wire logic cpuRead,
  input wire logic cpuBitWrite,
  input wire logic [2:0] cpuBitIdx,
  input wire logic cpuBitVal,
  output logic [7:0] cpuRdData,
  input wire logic serialDataIn,
  output logic serialDataOut,
  input wire logic serialShiftClockIn,
  output logic serialShiftClockOut,
  output logic serialShiftClockOe,
  output logic [7:0] rxData,
  output logic rxValid,
  input wire logic rxReady,
  output asmc_pkg::asmc_state_t engineState
);
  import asmc_pkg::*;
  localparam int AW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int DW = (SCK_HALF_DIV > 1) ? $clog2(SCK_HALF_DIV) : 1;

  initial
  begin
    if (BUF_DEPTH < 2 || BUF_DEPTH > 256)
      $error("asmc_auto_serial: BUF_DEPTH out of range");
    if (SCK_HALF_DIV < 1)
      $error("asmc_auto_serial: SCK_HALF_DIV must be at least 1");
  end

  logic [7:0] serial_auto_mode_control;
  logic [7:0] serialShiftReg;
  logic [7:0] transferEndPointer;
  logic [7:0] transferAddressCounter;
  logic serialTriggerReg;
  logic transferInProgressFlag;
  logic [7:0] bufMem [BUF_DEPTH];
  asmc_state_t state;
  logic [3:0] bitCount;
  logic [DW-1:0] divCount;
  logic masterClock;
  logic sckMeta, sckSync, sckPrev;
  logic sdiMeta, sdiSync;
  logic riseEdge, fallEdge, tick;
  logic resumeStall, roomNext;
  logic enable, autoMode, repeatMode, master, txEn, rxEn, lsbFirst;
  logic wrMode, wrTrig, wrShift, wrEnd, wrCnt, wrBuf, bufHit;
  logic [7:0] shiftedByte, nextMode;
  logic byteDone, atEnd, startAuto, startSingle, resumeRepeat;
  logic pushReady;
  logic [AW-1:0] cntIdx, bufIdx, nextIdx;

  assign enable = serial_auto_mode_control[`ASMC_BIT_ENABLE];
  assign autoMode = serial_auto_mode_control[`ASMC_BIT_AUTO];
  assign repeatMode = serial_auto_mode_control[`ASMC_BIT_REPEAT];
  assign master = serial_auto_mode_control[`ASMC_BIT_MASTER];
  assign txEn = serial_auto_mode_control[`ASMC_BIT_TX_EN];
  assign rxEn = serial_auto_mode_control[`ASMC_BIT_RX_EN];
  assign lsbFirst = serial_auto_mode_control[`ASMC_BIT_FIRST];
  assign engineState = state;

  assign wrMode = cpuWrite && cpuAddr == `ASMC_ADDR_MODE;
  assign wrTrig = cpuWrite && cpuAddr == `ASMC_ADDR_TRIGGER;
  assign wrShift = cpuWrite && cpuAddr == `ASMC_ADDR_SHIFT;
  assign wrEnd = cpuWrite && cpuAddr == `ASMC_ADDR_END_PTR;
  assign wrCnt = cpuWrite && cpuAddr == `ASMC_ADDR_ADDR_CNT;
  assign bufHit = cpuAddr >= `ASMC_ADDR_BUF_BASE &&
    cpuAddr < `ASMC_ADDR_BUF_BASE + 16'(BUF_DEPTH);
  assign bufIdx = AW'(cpuAddr - `ASMC_ADDR_BUF_BASE);
  assign wrBuf = cpuWrite && bufHit && enable;
  assign cntIdx = AW'(transferAddressCounter);
  assign nextIdx = AW'(transferAddressCounter + 8'h01);

  // mode register: byte write or single-bit write, bit 0 stays zero
  always_comb
  begin
    nextMode = serial_auto_mode_control;
    if (wrMode)
      nextMode = cpuWrData;
    else if (cpuBitWrite)
      nextMode[cpuBitIdx] = cpuBitVal;
    nextMode = nextMode & `ASMC_MODE_WMASK;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      serial_auto_mode_control <= `ASMC_MODE_RESET;
    else
      serial_auto_mode_control <= nextMode;
  end

  // pin inputs pass two flops; edges come from the second and third
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      sckMeta <= 1'b1;
      sckSync <= 1'b1;
      sckPrev <= 1'b1;
      sdiMeta <= 1'b0;
      sdiSync <= 1'b0;
    end
    else
    begin
      sckMeta <= serialShiftClockIn;
      sckSync <= sckMeta;
      sckPrev <= sckSync;
      sdiMeta <= serialDataIn;
      sdiSync <= sdiMeta;
    end
  end

  // internal clock divider runs only during a master byte
  assign tick = (divCount == DW'(SCK_HALF_DIV - 1));
  always_ff @(posedge clk)
  begin
    if (!resetn || !enable || state != ASMC_SHIFT || !master)
    begin
      divCount <= '0;
      masterClock <= 1'b1;
    end
    else if (tick)
    begin
      divCount <= '0;
      masterClock <= ~masterClock;
    end
    else
      divCount <= divCount + DW'(1);
  end

  always_comb
  begin
    if (master)
    begin
      fallEdge = tick && masterClock;
      riseEdge = tick && !masterClock;
    end
    else
    begin
      fallEdge = sckPrev && !sckSync;
      riseEdge = !sckPrev && sckSync;
    end
    if (state != ASMC_SHIFT)
    begin
      fallEdge = 1'b0;
      riseEdge = 1'b0;
    end
  end

  assign serialShiftClockOut = masterClock;
  assign serialShiftClockOe = master;

  // shift in on the rising edge, move the next bit out on the falling
  assign shiftedByte = lsbFirst ? {sdiSync && rxEn, serialShiftReg[7:1]}
    : {serialShiftReg[6:0], sdiSync && rxEn};
  assign byteDone = riseEdge && bitCount == `ASMC_BITS_PER_BYTE - 4'h1;
  assign atEnd = transferAddressCounter == transferEndPointer;
  assign startSingle = wrShift && enable && !autoMode && state == ASMC_IDLE &&
    pushReady;
  assign startAuto = wrTrig && cpuWrData[`ASMC_BIT_START] && enable &&
    autoMode && state == ASMC_IDLE && pushReady;
  assign resumeRepeat = state == ASMC_WAIT && wrCnt && cpuWrData == 8'h00 &&
    pushReady;
  assign resumeStall = state == ASMC_WAIT && !atEnd && pushReady;
  // chain only if the byte now ending leaves room for the next one
  assign roomNext = !rxEn || !rxValid || (pushReady && rxReady);

  always_ff @(posedge clk)
  begin
    if (!resetn || !enable)
    begin
      state <= ASMC_IDLE;
      bitCount <= 4'h0;
      serialShiftReg <= 8'h00;
      transferInProgressFlag <= 1'b0;
    end
    else
    begin
      case (state)
        ASMC_IDLE:
        begin
          if (startSingle)
          begin
            serialShiftReg <= cpuWrData;
            state <= ASMC_SHIFT;
            transferInProgressFlag <= 1'b1;
          end
          else if (startAuto)
          begin
            serialShiftReg <= bufMem[cntIdx];
            state <= ASMC_SHIFT;
            transferInProgressFlag <= 1'b1;
          end
          bitCount <= 4'h0;
        end
        ASMC_SHIFT:
        begin
          if (riseEdge)
          begin
            serialShiftReg <= shiftedByte;
            bitCount <= bitCount + 4'h1;
          end
          if (byteDone)
          begin
            bitCount <= 4'h0;
            if (!autoMode)
            begin
              state <= ASMC_IDLE;
              transferInProgressFlag <= 1'b0;
            end
            else if (atEnd && !repeatMode)
            begin
              state <= ASMC_IDLE;
              transferInProgressFlag <= 1'b0;
            end
            else if (atEnd || !roomNext)
              state <= ASMC_WAIT;
            else
              serialShiftReg <= bufMem[AW'(transferAddressCounter + 8'h01)];
          end
        end
        ASMC_WAIT:
        begin
          // repeat end, or a stalled receiver, holds the run here
          if (resumeRepeat)
          begin
            serialShiftReg <= bufMem[0];
            state <= ASMC_SHIFT;
          end
          else if (resumeStall)
          begin
            serialShiftReg <= bufMem[nextIdx];
            state <= ASMC_SHIFT;
          end
        end
        default:
          state <= ASMC_IDLE;
      endcase
    end
  end

  // data output: low when disabled or with transmit off; otherwise holds its last bit between bytes
  always_ff @(posedge clk)
  begin
    if (!resetn || !enable || !txEn)
      serialDataOut <= 1'b0;
    else if (state == ASMC_IDLE && (startSingle || startAuto))
      serialDataOut <= startSingle ? (lsbFirst ? cpuWrData[0] : cpuWrData[7])
        : (lsbFirst ? bufMem[cntIdx][0] : bufMem[cntIdx][7]);
    else if (fallEdge)
      serialDataOut <= lsbFirst ? serialShiftReg[0] : serialShiftReg[7];
    else if (resumeRepeat || resumeStall)
      serialDataOut <= resumeRepeat ?
        (lsbFirst ? bufMem[0][0] : bufMem[0][7]) :
        (lsbFirst ? bufMem[nextIdx][0] : bufMem[nextIdx][7]);
  end

  // address counter and trigger
  always_ff @(posedge clk)
  begin
    if (!resetn || !enable)
    begin
      transferAddressCounter <= 8'h00;
      serialTriggerReg <= 1'b0;
    end
    else
    begin
      if (wrCnt)
        transferAddressCounter <= cpuWrData;
      else if ((byteDone && autoMode && !atEnd && roomNext) || resumeStall)
        transferAddressCounter <= transferAddressCounter + 8'h01;
      if (byteDone && autoMode && atEnd && !repeatMode)
        serialTriggerReg <= 1'b0;
      else if (startAuto)
        serialTriggerReg <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      transferEndPointer <= 8'h00;
    else if (wrEnd)
      transferEndPointer <= cpuWrData;
  end

  // buffer memory has no reset; contents are kept over a disable
  always_ff @(posedge clk)
  begin
    if (wrBuf)
      bufMem[bufIdx] <= cpuWrData;
    else if (byteDone && autoMode && rxEn)
      bufMem[cntIdx] <= shiftedByte;
  end

  // received bytes leave through the buffer; a full buffer stalls starts
  asmc_buf2 #(
    .WIDTH(8)
  ) rxBuffer (
    .clk(clk),
    .resetn(resetn),
    .flush(!enable),
    .inData(shiftedByte),
    .inValid(byteDone && rxEn),
    .inReady(pushReady),
    .outData(rxData),
    .outValid(rxValid),
    .outReady(rxReady)
  );

  // read path, buffer reads as zero while disabled
  always_ff @(posedge clk)
  begin
    if (!resetn)
      cpuRdData <= 8'h00;
    else if (cpuRead)
    begin
      if (cpuAddr == `ASMC_ADDR_MODE)
        cpuRdData <= serial_auto_mode_control;
      else if (cpuAddr == `ASMC_ADDR_STATUS)
        cpuRdData <= {7'h00, transferInProgressFlag};
      else if (cpuAddr == `ASMC_ADDR_TRIGGER)
        cpuRdData <= {7'h00, serialTriggerReg};
      else if (cpuAddr == `ASMC_ADDR_SHIFT)
        cpuRdData <= serialShiftReg;
      else if (cpuAddr == `ASMC_ADDR_END_PTR)
        cpuRdData <= transferEndPointer;
      else if (cpuAddr == `ASMC_ADDR_ADDR_CNT)
        cpuRdData <= transferAddressCounter;
      else if (bufHit && enable)
        cpuRdData <= bufMem[bufIdx];
      else
        cpuRdData <= 8'h00;
    end
  end
endmodule : asmc_auto_serial
`default_nettype wire

// *** bench/asmc_chk.sv ***
// port checker for the auto serial unit
`timescale 1ns/100ps
`default_nettype none
`include "asmc_defs.svh"
module asmc_chk
  import asmc_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [15:0] cpuAddr,
  input wire logic [7:0] cpuWrData,
  input wire logic cpuWrite,
  input wire logic cpuRead,
  input wire logic cpuBitWrite,
  input wire logic [2:0] cpuBitIdx,
  input wire logic cpuBitVal,
  input wire logic [7:0] cpuRdData,
  input wire logic serialDataOut,
  input wire logic serialShiftClockOut,
  input wire logic serialShiftClockOe,
  input wire logic rxValid,
  input wire asmc_pkg::asmc_state_t engineState
);
  logic [7:0] m;
  logic [3:0] rises;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // shadow of the mode register, rebuilt from the write traffic
  always_ff @(posedge clk)
  begin
    if (!resetn)
      m <= 8'h00;
    else if (cpuWrite && cpuAddr == `ASMC_ADDR_MODE)
      m <= cpuWrData & `ASMC_MODE_WMASK;
    else if (cpuBitWrite && cpuBitIdx != 3'h0)
      m[cpuBitIdx] <= cpuBitVal;
  end
  always_ff @(posedge clk)
  begin
    if (!resetn || engineState != ASMC_SHIFT)
      rises <= 4'h0;
    else if ($rose(serialShiftClockOut))
      rises <= rises + 4'h1;
  end
  sequence s_off;
    !m[7] ##1 !m[7];
  endsequence
  sequence s_on;
    m[7] ##1 m[7];
  endsequence
  property p_rd_mode;
    cpuRead && cpuAddr == `ASMC_ADDR_MODE |=> cpuRdData == $past(m);
  endproperty
  a_rd_mode: assert property (p_rd_mode)
    else $error("mode register read mismatch");
  property p_off_pins;
    s_off |-> !serialDataOut && serialShiftClockOut;
  endproperty
  a_off_pins: assert property (p_off_pins)
    else $error("disabled pins not at idle levels");
  property p_off_state;
    s_off |-> engineState == ASMC_IDLE && !rxValid;
  endproperty
  a_off_state: assert property (p_off_state)
    else $error("disabled unit keeps state");
  property p_busy;
    cpuRead && cpuAddr == `ASMC_ADDR_STATUS |=>
      cpuRdData[0] == ($past(engineState) != ASMC_IDLE);
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy flag disagrees with engine");
  property p_start;
    cpuWrite && cpuAddr == `ASMC_ADDR_SHIFT && m[7] && !m[6] &&
      engineState == ASMC_IDLE && !rxValid |=> engineState == ASMC_SHIFT;
  endproperty
  a_start: assert property (p_start)
    else $error("single byte did not start");
  property p_oe;
    s_on |-> serialShiftClockOe == m[4];
  endproperty
  a_oe: assert property (p_oe)
    else $error("clock drive does not follow master bit");
  property p_tx_off;
    !m[3] ##1 !m[3] |-> !serialDataOut;
  endproperty
  a_tx_off: assert property (p_tx_off)
    else $error("data out not low with transmit off");
  property p_eight;
    $fell(engineState == ASMC_SHIFT) && m[7] && m[4] && !m[6] |->
      rises + {3'h0, $rose(serialShiftClockOut)} == 4'h8;
  endproperty
  a_eight: assert property (p_eight)
    else $error("byte did not take eight clocks");
  property p_hold;
    $rose(serialShiftClockOut) && engineState == ASMC_SHIFT |->
      $stable(serialDataOut);
  endproperty
  a_hold: assert property (p_hold)
    else $error("data moved on the sampling edge");
endmodule : asmc_chk
bind asmc_auto_serial asmc_chk chk (.*);
`default_nettype wire

// *** bench/asmc_partner.sv ***
// peripheral model on the far side of the three-wire link
`timescale 1ns/100ps
`default_nettype none
module asmc_partner (
  input wire logic sckOut,
  input wire logic sckOe,
  input wire logic dout,
  input wire logic lsb,
  input wire logic go,
  input wire logic clr,
  input wire logic [7:0] txByte,
  output logic din,
  output logic sckIn,
  output logic [7:0] got
);
  logic sck;
  logic [7:0] sh;
  int n;
  assign sck = sckOe ? sckOut : sckIn;
  initial
  begin
    sckIn = 1'b1;
    din = 1'b0;
    got = 8'h00;
    sh = 8'h00;
    n = 0;
  end
  always @(posedge clr)
    n = 0;
  // clock stands high between slave frames
  always @(posedge go)
    repeat (8)
    begin
      #80 sckIn = 1'b0;
      #80 sckIn = 1'b1;
    end
  always @(negedge sck)
    din = lsb ? txByte[n] : txByte[7 - n];
  always @(posedge sck)
  begin
    if (!clr)
    begin
      sh = lsb ? {dout, sh[7:1]} : {sh[6:0], dout};
      n = (n + 1) % 8;
      if (n == 0)
      begin
        got = sh;
        din <= #60 ~din; // released once the far side has sampled
      end
    end
  end
endmodule : asmc_partner
`default_nettype wire

// *** bench/test_auto_serial_mode_control.sv ***
// self-checking bench of the auto serial unit
`timescale 1ns/100ps
`default_nettype none
module test_auto_serial_mode_control;
  import asmc_pkg::*;
  logic clk, resetn, cpuWrite, cpuRead, cpuBitWrite, cpuBitVal;
  logic [15:0] cpuAddr;
  logic [7:0] cpuWrData, cpuRdData, rxData, peerByte, peerGot;
  logic [2:0] cpuBitIdx;
  logic din, dout, sckIn, sckOut, sckOe, rxValid, rxReady;
  logic lsbFirst, slaveGo, peerClr;
  asmc_state_t engineState;
  int errTotal, testsRun, cyc;
  asmc_auto_serial uut (.clk(clk), .resetn(resetn), .cpuAddr(cpuAddr),
    .cpuWrData(cpuWrData), .cpuWrite(cpuWrite), .cpuRead(cpuRead),
    .cpuBitWrite(cpuBitWrite), .cpuBitIdx(cpuBitIdx),
    .cpuBitVal(cpuBitVal), .cpuRdData(cpuRdData), .serialDataIn(din),
    .serialDataOut(dout), .serialShiftClockIn(sckIn),
    .serialShiftClockOut(sckOut), .serialShiftClockOe(sckOe),
    .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady),
    .engineState(engineState));
  asmc_partner peer (.sckOut(sckOut), .sckOe(sckOe), .dout(dout),
    .lsb(lsbFirst), .go(slaveGo), .clr(peerClr), .txByte(peerByte),
    .din(din), .sckIn(sckIn), .got(peerGot));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic tallyAndFinish;
    $display("comparisons %0d mismatches %0d", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tallyAndFinish
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      errTotal++;
      tallyAndFinish();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      errTotal++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    cpuAddr = a;
    cpuWrData = d;
    cpuWrite = 1'b1;
    @(posedge clk);
    #1;
    cpuWrite = 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    #1;
    cpuAddr = a;
    cpuRead = 1'b1;
    @(posedge clk);
    #1;
    cpuRead = 1'b0;
    chk(cpuRdData, e);
  endtask : rd
  task automatic bitw(input logic [2:0] i, input logic v);
    @(posedge clk);
    #1;
    cpuBitIdx = i;
    cpuBitVal = v;
    cpuBitWrite = 1'b1;
    @(posedge clk);
    #1;
    cpuBitWrite = 1'b0;
  endtask : bitw
  task automatic waitSt(input asmc_state_t s);
    for (int i = 0; i < 3000 && engineState !== s; i++)
    begin
      @(posedge clk);
      #2;
    end
    chk({6'h00, engineState}, {6'h00, s});
  endtask : waitSt
  task automatic popChk(input logic [7:0] e);
    for (int i = 0; i < 10 && rxValid !== 1'b1; i++)
    begin
      @(posedge clk);
      #2;
    end
    chk({7'h00, rxValid}, 8'h01);
    chk(rxData, e);
    @(posedge clk);
    #1;
    rxReady = 1'b1;
    @(posedge clk);
    #1;
    rxReady = 1'b0;
  endtask : popChk
  task automatic xfer(input logic [7:0] md);
    lsbFirst = md[1];
    wr(16'hff90, md);
    wr(16'hff93, 8'h1e);
    if (!md[4])
    begin
      slaveGo = 1'b1;
      @(posedge clk);
      #1;
      slaveGo = 1'b0;
    end
    waitSt(ASMC_IDLE);
  endtask : xfer
  task automatic tRegs;
    rd(16'hff90, 8'h00);
    chk({6'h00, sckOut, dout}, 8'h02);
    wr(16'hff90, 8'h7f);
    rd(16'hff90, 8'h7e);
    bitw(3'h7, 1'b1);
    bitw(3'h0, 1'b1);
    bitw(3'h2, 1'b0);
    rd(16'hff90, 8'hfa);
    rd(16'h1234, 8'h00);
    $display("registers done");
  endtask : tRegs
  task automatic tBytes;
    peerByte = 8'h35;
    xfer(8'h9c);
    chk(peerGot, 8'h1e);
    popChk(8'h35);
    peerByte = 8'h0f;
    xfer(8'h9e);
    chk(peerGot, 8'h1e);
    popChk(8'h0f);
    peerByte = 8'h35;
    xfer(8'h8c);
    chk({7'h00, sckOe}, 8'h00);
    chk(peerGot, 8'h1e);
    popChk(8'h35);
    xfer(8'h90);
    chk(peerGot, 8'h00);
    repeat (4) @(posedge clk);
    chk({7'h00, rxValid}, 8'h00);
    $display("single bytes done");
  endtask : tBytes
  task automatic tDisable;
    wr(16'hff90, 8'h9c);
    wr(16'hfa00, 8'h55);
    rd(16'hfa00, 8'h55);
    wr(16'hff93, 8'h1e);
    repeat (20) @(posedge clk);
    wr(16'hff90, 8'h1c);
    @(posedge clk);
    #2;
    chk({6'h00, engineState}, {6'h00, ASMC_IDLE});
    chk({6'h00, sckOut, dout}, 8'h02);
    rd(16'hff91, 8'h00);
    rd(16'hff92, 8'h00);
    rd(16'hff93, 8'h00);
    rd(16'hfa00, 8'h00);
    peerClr = 1'b1;
    wr(16'hff90, 8'h9c);
    peerClr = 1'b0;
    wr(16'hfa00, 8'h66);
    rd(16'hfa00, 8'h66);
    $display("disable done");
  endtask : tDisable
  task automatic tAuto;
    wr(16'hff90, 8'hdc);
    for (int i = 0; i < 3; i++)
      wr(16'hfa00 + 16'(i), 8'h10 + 8'(i));
    wr(16'hff94, 8'h02);
    wr(16'hff95, 8'h00);
    peerByte = 8'h35;
    wr(16'hff92, 8'h01);
    waitSt(ASMC_WAIT);
    rd(16'hff91, 8'h01);
    popChk(8'h35);
    popChk(8'h35);
    waitSt(ASMC_IDLE);
    chk(peerGot, 8'h12);
    popChk(8'h35);
    rd(16'hff92, 8'h00);
    rd(16'hfa02, 8'h35);
    $display("auto single done");
  endtask : tAuto
  task automatic tRepeat;
    wr(16'hff90, 8'hfc);
    wr(16'hff94, 8'h00);
    wr(16'hff95, 8'h00);
    rxReady = 1'b1;
    wr(16'hff92, 8'h01);
    waitSt(ASMC_WAIT);
    repeat (100) @(posedge clk);
    rd(16'hff91, 8'h01);
    wr(16'hff95, 8'h00);
    waitSt(ASMC_SHIFT);
    waitSt(ASMC_WAIT);
    wr(16'hff90, 8'h00);
    rxReady = 1'b0;
    $display("auto repeat done");
  endtask : tRepeat
  initial
  begin
    {resetn, cpuWrite, cpuRead, cpuBitWrite, cpuBitVal} = 5'h00;
    {cpuAddr, cpuWrData, cpuBitIdx, peerByte} = 35'h0;
    {rxReady, lsbFirst, slaveGo, peerClr} = 4'h1;
    {errTotal, testsRun, cyc} = 96'h0;
    repeat (4) @(posedge clk);
    #1;
    resetn = 1'b1;
    peerClr = 1'b0;
    tRegs();
    tBytes();
    tDisable();
    tAuto();
    tRepeat();
    tallyAndFinish();
  end
endmodule : test_auto_serial_mode_control
`default_nettype wire
